// [common/strap_group_if.sv]
// Carrier between the top block and one strap latch group
`timescale 1ns/100ps
interface strap_group_if #(parameter int W = 1);
  logic         clk_en;
  logic         qual;
  logic [W-1:0] pad;
  logic [W-1:0] value;
  logic         pd_en;
  logic         captured;

  modport latch (input clk_en, input qual, input pad,
                 output value, output pd_en, output captured);
  modport owner (output clk_en, output qual, output pad,
                 input value, input pd_en, input captured);
endinterface

// [common/strap_pkg.sv]
// Constants shared by the strap capture block and its latch groups
package strap_pkg;

  // APB register map
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam logic [11:0] CTRL_OFF    = 12'h000;
  localparam logic [11:0] STATUS_OFF  = 12'h004;
  localparam logic [11:0] HEALTH_OFF  = 12'h008;

  // Control register fields
  localparam int          CTRL_PORT_F_BIT    = 0;
  localparam int          CTRL_COMPANION_BIT = 1;
  localparam int          CTRL_W             = 2;
  localparam logic [1:0]  CTRL_RST           = 2'h0;

  // Straps sampled at resume reset release
  localparam int          RSM_W        = 7;
  localparam int          RSM_SHARING  = 0;
  localparam int          RSM_CRYSTAL  = 1;
  localparam int          RSM_WIRELESS = 2;
  localparam int          RSM_SUPPLY   = 3;
  localparam int          RSM_ESPI     = 4;
  localparam int          RSM_PROBE    = 5;
  localparam int          RSM_IO3      = 6;
  localparam logic [6:0]  RSM_DEFAULT  = 7'h60;

  // Straps sampled at platform power-good
  localparam int          PWR_W        = 5;
  localparam int          PWR_OVERRIDE = 0;
  localparam int          PWR_PORT_B   = 1;
  localparam int          PWR_PORT_C   = 2;
  localparam int          PWR_PORT_D   = 3;
  localparam int          PWR_PORT_F   = 4;
  localparam logic [4:0]  PWR_DEFAULT  = 5'h00;
  localparam int          PORTS_W      = 4;

  // Strap sampled at deep-sleep-well power-good
  localparam int          DSW_W        = 1;
  localparam logic [0:0]  DSW_DEFAULT  = 1'h1;

  // Status register layout
  localparam int          ST_RSM_LSB   = 0;
  localparam int          ST_PWR_LSB   = 8;
  localparam int          ST_DSW_BIT   = 16;

  // Health register bits
  localparam int          HL_RSM_DONE  = 0;
  localparam int          HL_PWR_DONE  = 1;
  localparam int          HL_DSW_DONE  = 2;
  localparam int          HL_CONFLICT  = 3;
  localparam int          HL_XTAL_BAD  = 4;
  localparam int          HL_RSVD_LOW  = 5;
  localparam int          HL_OVERRIDE  = 6;

endpackage

// [core/boot_strap_capture.sv]
// Boot strap capture block with APB status and control registers
`timescale 1ns/100ps
module boot_strap_capture
  import strap_pkg::*;
(
  // Clock, reset and enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power and reset qualifiers
  input  wire logic              resume_reset_n,
  input  wire logic              platform_power_good,
  input  wire logic              deep_sleep_power_good,
  // Strap pads sampled at platform power-good
  input  wire logic              audio_serial_out_pad,
  input  wire logic              port_b_detect_pad,
  input  wire logic              port_c_detect_pad,
  input  wire logic              port_d_detect_pad,
  input  wire logic              port_f_detect_pad,
  // Strap pads sampled at resume reset release
  input  wire logic              flash_sharing_strap_pad,
  input  wire logic              crystal_select_strap_pad,
  input  wire logic              wireless_mode_strap_pad,
  input  wire logic              flash_supply_strap_pad,
  input  wire logic              espi_select_strap_pad,
  input  wire logic              probe_mode_reserved_strap,
  input  wire logic              flash_io3_reserved_strap,
  // Strap pad sampled at deep-sleep power-good
  input  wire logic              deep_sleep_reserved_strap,
  // Pad pull-down enables
  output logic                   audio_serial_out_pd_en,
  output logic                   display_detect_pd_en,
  output logic                   resume_straps_pd_en,
  output logic                   wireless_mode_pd_en,
  // Captured settings
  output logic                   descriptor_security_off,
  output logic                   target_attached_sharing,
  output logic      [PORTS_W-1:0] display_port_present,
  output logic                   crystal_24mhz,
  output logic                   integrated_wireless_disable,
  output logic                   serial_flash_supply_1v8,
  output logic                   espi_selected
);

  strap_group_if #(.W(RSM_W)) rsm_if ();
  strap_group_if #(.W(PWR_W)) pwr_if ();
  strap_group_if #(.W(DSW_W)) dsw_if ();

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [PORTS_W-1:0] ports_next;
  logic               wr_en;
  logic               rd_en;
  logic               hit;
  logic               wr_commit;
  logic               sel_ctrl;
  logic               sel_status;
  logic               sel_health;
  logic [DATA_W-1:0]  rdata_next;
  logic [DATA_W-1:0]  status_word;
  logic [DATA_W-1:0]  health_word;

  // Qualifier hookup, one latch group per sampling edge
  assign rsm_if.clk_en = clk_en;
  assign rsm_if.qual   = resume_reset_n;
  assign rsm_if.pad    = {flash_io3_reserved_strap,
                          probe_mode_reserved_strap,
                          espi_select_strap_pad,
                          flash_supply_strap_pad,
                          wireless_mode_strap_pad,
                          crystal_select_strap_pad,
                          flash_sharing_strap_pad};

  assign pwr_if.clk_en = clk_en;
  assign pwr_if.qual   = platform_power_good;
  assign pwr_if.pad    = {port_f_detect_pad,
                          port_d_detect_pad,
                          port_c_detect_pad,
                          port_b_detect_pad,
                          audio_serial_out_pad};

  assign dsw_if.clk_en = clk_en;
  assign dsw_if.qual   = deep_sleep_power_good;
  assign dsw_if.pad    = deep_sleep_reserved_strap;

  // Resume-well group: sharing, crystal, wireless, supply, eSPI, reserved
  strap_latch #(
    .W       (RSM_W),
    .DEFAULT (RSM_DEFAULT)
  ) u_rsm (
    .pclk    (pclk),
    .presetn (presetn),
    .grp     (rsm_if.latch)
  );

  // Platform group: descriptor override and display detects
  strap_latch #(
    .W       (PWR_W),
    .DEFAULT (PWR_DEFAULT)
  ) u_pwr (
    .pclk    (pclk),
    .presetn (presetn),
    .grp     (pwr_if.latch)
  );

  // Deep-sleep group, independent of the other two qualifiers
  strap_latch #(
    .W       (DSW_W),
    .DEFAULT (DSW_DEFAULT)
  ) u_dsw (
    .pclk    (pclk),
    .presetn (presetn),
    .grp     (dsw_if.latch)
  );

  // Settings taken straight from the latch flops
  assign descriptor_security_off     = pwr_if.value[PWR_OVERRIDE];
  assign target_attached_sharing     = rsm_if.value[RSM_SHARING];
  assign crystal_24mhz               = rsm_if.value[RSM_CRYSTAL];
  assign integrated_wireless_disable = rsm_if.value[RSM_WIRELESS];
  assign serial_flash_supply_1v8     = rsm_if.value[RSM_SUPPLY];
  assign espi_selected               = rsm_if.value[RSM_ESPI];
  assign audio_serial_out_pd_en      = pwr_if.pd_en;
  assign display_detect_pd_en        = pwr_if.pd_en;
  assign resume_straps_pd_en         = rsm_if.pd_en;

  // Port F is gated so an unsupported port cannot report present
  always_comb begin
    ports_next = pwr_if.value[PWR_PORT_F:PWR_PORT_B];
    if (!ctrl_reg[CTRL_PORT_F_BIT]) begin
      ports_next[PORTS_W-1] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_port_present <= '0;
    end else if (clk_en) begin
      display_port_present <= ports_next;
    end
  end

  // Companion attached keeps the pull-down on, holding the enable level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wireless_mode_pd_en <= 1'b0;
    end else if (clk_en) begin
      wireless_mode_pd_en <= ctrl_reg[CTRL_COMPANION_BIT];
    end
  end

  // APB decode; one wait state so read data comes from a flop
  assign sel_ctrl   = (paddr == CTRL_OFF);
  assign sel_status = (paddr == STATUS_OFF);
  assign sel_health = (paddr == HEALTH_OFF);
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign hit   = sel_ctrl | sel_status | sel_health;
  // A write lands only at the edge where the master sees pready, never earlier
  assign wr_commit = psel & penable & pwrite & pready;

  always_comb begin
    status_word                                   = '0;
    status_word[ST_RSM_LSB +: RSM_W]              = rsm_if.value;
    status_word[ST_PWR_LSB +: PWR_W]              = pwr_if.value;
    status_word[ST_PWR_LSB + PWR_PORT_F]          = ports_next[PORTS_W-1];
    status_word[ST_DSW_BIT]                       = dsw_if.value[0];
  end

  // Board-side obligations are only observed and reported, never enforced
  always_comb begin
    health_word              = '0;
    health_word[HL_RSM_DONE] = rsm_if.captured;
    health_word[HL_PWR_DONE] = pwr_if.captured;
    health_word[HL_DSW_DONE] = dsw_if.captured;
    health_word[HL_CONFLICT] = rsm_if.captured & ~rsm_if.value[RSM_ESPI]
                               & rsm_if.value[RSM_SHARING];
    health_word[HL_XTAL_BAD] = rsm_if.captured & ~rsm_if.value[RSM_CRYSTAL];
    health_word[HL_RSVD_LOW] = (rsm_if.captured & ~(rsm_if.value[RSM_PROBE]
                               & rsm_if.value[RSM_IO3]))
                               | (dsw_if.captured & ~dsw_if.value[0]);
    health_word[HL_OVERRIDE] = pwr_if.captured & pwr_if.value[PWR_OVERRIDE];
  end

  always_comb begin
    rdata_next = '0;
    unique case (paddr)
      CTRL_OFF:   rdata_next[CTRL_W-1:0] = ctrl_reg;
      STATUS_OFF: rdata_next = status_word;
      HEALTH_OFF: rdata_next = health_word;
      default:    rdata_next = '0;
    endcase
  end

  // Control register, low byte lane only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (clk_en) begin
      if (wr_commit && sel_ctrl && pstrb[0]) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
    end
  end

  // Unmapped addresses answer with an error; writes to status are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= (wr_en | rd_en) & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (clk_en) begin
      if (rd_en) begin
        prdata <= rdata_next;
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule // boot_strap_capture

// [core/strap_latch.sv]
// One group of straps captured on the rising edge of a common qualifier
`timescale 1ns/100ps
module strap_latch
  import strap_pkg::*;
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] DEFAULT = '0
) (
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Group signals
  strap_group_if.latch  grp
);

  logic qual_d_reg;
  logic rise;

  assign rise = grp.qual & ~qual_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_d_reg <= 1'b0;
    end else if (grp.clk_en) begin
      qual_d_reg <= grp.qual;
    end
  end

  // Each bit latches alone so a pad stays unaffected by its neighbours
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          grp.value[i] <= DEFAULT[i];
        end else if (grp.clk_en) begin
          if (!grp.qual) begin
            grp.value[i] <= DEFAULT[i];
          end else if (rise) begin
            grp.value[i] <= grp.pad[i];
          end
        end
      end
    end
  endgenerate

  // Pull-down stays on while the qualifier is low, drops once sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp.pd_en    <= 1'b1;
      grp.captured <= 1'b0;
    end else if (grp.clk_en) begin
      if (!grp.qual) begin
        grp.pd_en    <= 1'b1;
        grp.captured <= 1'b0;
      end else if (rise) begin
        grp.pd_en    <= 1'b0;
        grp.captured <= 1'b1;
      end
    end
  end

endmodule // strap_latch

// [test/boot_strap_capture_asserts.sv]
// Port-level assertions for the boot strap capture block
`timescale 1ns/100ps
module boot_strap_capture_asserts
  import strap_pkg::*;
(
  // Clock, reset and APB answer
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [DATA_W-1:0] prdata,
  // Qualifiers and pads
  input wire logic resume_reset_n, platform_power_good, audio_serial_out_pad,
  input wire logic port_b_detect_pad, port_c_detect_pad, port_d_detect_pad,
  input wire logic flash_sharing_strap_pad, crystal_select_strap_pad,
  input wire logic wireless_mode_strap_pad, flash_supply_strap_pad, espi_select_strap_pad,
  // Pull-downs and settings
  input wire logic audio_serial_out_pd_en, display_detect_pd_en, resume_straps_pd_en,
  input wire logic descriptor_security_off, target_attached_sharing, crystal_24mhz,
  input wire logic integrated_wireless_disable, serial_flash_supply_1v8, espi_selected,
  input wire logic [PORTS_W-1:0] display_port_present
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_apb_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("access not answered after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data not zero while idle");
  chk_sharing_latch: assert property ($rose(resume_reset_n) |=>
    target_attached_sharing == $past(flash_sharing_strap_pad)) else $error("sharing latch");
  chk_crystal_latch: assert property ($rose(resume_reset_n) |=>
    crystal_24mhz == $past(crystal_select_strap_pad)) else $error("crystal latch");
  chk_resume_latch: assert property ($rose(resume_reset_n) |=>
    {integrated_wireless_disable, serial_flash_supply_1v8, espi_selected} ==
    $past({wireless_mode_strap_pad, flash_supply_strap_pad, espi_select_strap_pad}))
    else $error("resume group latch");
  chk_power_latch: assert property ($rose(platform_power_good) |=>
    descriptor_security_off == $past(audio_serial_out_pad) ##1 display_port_present[2:0] ==
    $past({port_d_detect_pad, port_c_detect_pad, port_b_detect_pad}, 2))
    else $error("power-good group latch");
  chk_power_pd_off: assert property (platform_power_good && $past(platform_power_good) |->
    !audio_serial_out_pd_en && !display_detect_pd_en) else $error("pull-down left on");
  chk_resume_pd_off: assert property (resume_reset_n && $past(resume_reset_n) |->
    !resume_straps_pd_en) else $error("resume pull-down left on");
  chk_power_hold: assert property (platform_power_good && $past(platform_power_good) &&
    $past(platform_power_good, 2) |-> $stable(descriptor_security_off)) else $error("override moved");
  chk_resume_hold: assert property (resume_reset_n && $past(resume_reset_n) &&
    $past(resume_reset_n, 2) |-> $stable(target_attached_sharing)) else $error("sharing moved");
  cover property ($rose(resume_reset_n));
  cover property ($rose(platform_power_good) ##1 descriptor_security_off);
  cover property (pslverr);
endmodule // boot_strap_capture_asserts
bind boot_strap_capture boot_strap_capture_asserts u_chk (.*);

// [test/boot_strap_capture_tb_top.sv]
// Self-checking bench for the boot strap capture block
`timescale 1ns/100ps
module boot_strap_capture_tb_top
  import strap_pkg::*;
;
  typedef struct {logic [31:0] d; logic e; logic [13:0] o; logic rd;} note_t;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic rsm_q = 0, pwr_q = 0, dsw_q = 0, rogue = 0, pready, pslverr;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [12:0] cfg = '0;
  logic [4:0] pwr_pads, pwr_x;
  logic [6:0] rsm_pads, rsm_x;
  logic [1:0] ctrl_x;
  logic [PORTS_W-1:0] ports;
  logic dsw_pad, dsw_x, rdone, pdone, ddone;
  logic a_pd, d_pd, r_pd, w_pd, sec_off, share, xtal, wl_dis, v18, espi;
  wire [13:0] outs = {sec_off, share, ports, espi, v18, wl_dis, xtal, a_pd, d_pd, r_pd, w_pd};
  note_t notes[$];
  int failures = 0, comparisons = 0, seed = 32'h298d2909;

  always #25 pclk = ~pclk;

  strap_board_model u_board (.cfg(cfg), .rogue(rogue), .wl_pd_en(w_pd), .pwr_pads(pwr_pads),
    .rsm_pads(rsm_pads), .dsw_pad(dsw_pad));

  boot_strap_capture u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .resume_reset_n(rsm_q),
    .platform_power_good(pwr_q), .deep_sleep_power_good(dsw_q),
    .audio_serial_out_pad(pwr_pads[0]), .port_b_detect_pad(pwr_pads[1]),
    .port_c_detect_pad(pwr_pads[2]), .port_d_detect_pad(pwr_pads[3]),
    .port_f_detect_pad(pwr_pads[4]), .flash_sharing_strap_pad(rsm_pads[0]),
    .crystal_select_strap_pad(rsm_pads[1]), .wireless_mode_strap_pad(rsm_pads[2]),
    .flash_supply_strap_pad(rsm_pads[3]), .espi_select_strap_pad(rsm_pads[4]),
    .probe_mode_reserved_strap(rsm_pads[5]), .flash_io3_reserved_strap(rsm_pads[6]),
    .deep_sleep_reserved_strap(dsw_pad), .audio_serial_out_pd_en(a_pd),
    .display_detect_pd_en(d_pd), .resume_straps_pd_en(r_pd), .wireless_mode_pd_en(w_pd),
    .descriptor_security_off(sec_off), .target_attached_sharing(share),
    .display_port_present(ports), .crystal_24mhz(xtal), .integrated_wireless_disable(wl_dis),
    .serial_flash_supply_1v8(v18), .espi_selected(espi));

  function automatic logic [13:0] outs_x();
    return {pwr_x[0], rsm_x[0], pwr_x[4] & ctrl_x[0], pwr_x[3:1], rsm_x[4:1],
            ~pdone, ~pdone, ~rdone, ctrl_x[1]};
  endfunction
  function automatic logic [31:0] status_x();
    return {15'h0, dsw_x, 3'h0, pwr_x[4] & ctrl_x[0], pwr_x[3:0], 1'b0, rsm_x};
  endfunction
  function automatic logic [31:0] health_x();
    return {25'h0, pwr_x[0], ~&{rsm_x[6:5], dsw_x}, ~rsm_x[1], rsm_x[0] & ~rsm_x[4],
            ddone, pdone, rdone};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_err(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cmp_pins(input logic [13:0] got, input logic [13:0] exp);
    cmp({18'h0, got}, {18'h0, exp});
  endtask
  // The answer is checked by the monitor, so the master only waits for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    notes.push_back('{xd, xe, outs_x(), !w});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic quals(input logic r, input logic p, input logic d);
    @(posedge pclk);
    rsm_q <= r;
    pwr_q <= p;
    dsw_q <= d;
  endtask
  task automatic tally_and_finish();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    note_t n;
    if (pready === 1'b1) begin
      n = notes.pop_front();
      cmp_err(pslverr, n.e);
      if (n.rd) begin
        cmp(prdata, n.d);
        cmp_pins(outs, n.o);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rsm_x = RSM_DEFAULT; pwr_x = PWR_DEFAULT; dsw_x = DSW_DEFAULT[0]; ctrl_x = CTRL_RST;
    {rdone, pdone, ddone} = 3'b000;
    apb(STATUS_OFF, 0, 0, status_x(), 0);
    apb(12'hffc, 1, 32'hffff_ffff, 0, 1);
    for (int i = 0; i < 8; i++) begin
      quals(0, 0, 0);
      {rdone, pdone, ddone} = 3'b000;
      cfg <= 13'($random(seed));
      rogue <= i[0];
      ctrl_x = 2'($random(seed));
      apb(CTRL_OFF, 1, {30'h0, ctrl_x}, 0, 0);
      quals(1, 1, 0);
      @(posedge pclk);
      rsm_x = rsm_pads;
      pwr_x = pwr_pads;
      rdone = 1;
      pdone = 1;
      cfg <= 13'($random(seed));
      quals(1, 1, 1);
      @(posedge pclk);
      dsw_x = dsw_pad;
      ddone = 1;
      // Pads move after capture and must leave the settings alone
      cfg <= 13'($random(seed));
      apb(STATUS_OFF, 0, 0, status_x(), 0);
      apb(HEALTH_OFF, 0, 0, health_x(), 0);
      apb(STATUS_OFF, 1, 32'($random(seed)), 0, 0);
      apb(CTRL_OFF, 0, 0, {30'h0, ctrl_x}, 0);
      apb(STATUS_OFF, 0, 0, status_x(), 0);
      apb(12'h00c, 0, 0, 0, 1);
    end
    repeat (4) @(posedge pclk);
    tally_and_finish();
  end
endmodule // boot_strap_capture_tb_top

// [test/strap_board_model.sv]
// Board strap resistors and attached parts facing the capture block
`timescale 1ns/100ps
module strap_board_model (
  // Setting and fault control
  input  wire logic [12:0] cfg,
  input  wire logic        rogue,
  input  wire logic        wl_pd_en,
  // Strap pads
  output logic      [4:0]  pwr_pads,
  output logic      [6:0]  rsm_pads,
  output logic             dsw_pad
);
  // A rogue board breaks the strapping rules so the health flags get exercised
  assign pwr_pads      = {cfg[4:1], cfg[0] & rogue};
  assign rsm_pads[0]   = cfg[5] & (cfg[9] | rogue);
  assign rsm_pads[1]   = cfg[6] | ~rogue;
  assign rsm_pads[2]   = cfg[7] & ~wl_pd_en;
  assign rsm_pads[3]   = cfg[8];
  assign rsm_pads[4]   = cfg[9];
  assign rsm_pads[6:5] = cfg[11:10] | {2{~rogue}};
  assign dsw_pad       = cfg[12] | ~rogue;
endmodule // strap_board_model
